//--- hdl/rsp_sequencer.sv
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "rsp_defines.svh"
module rsp_sequencer #(
  parameter int NPH       = 8,
  parameter int INIT_CYC  = `RSP_INIT_CYC,
  parameter int RAMP_STEP = `RSP_RAMP_STEP_CYC
) (
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  input  wire logic [7:0]     addr,
  input  wire logic [15:0]    wdata,
  input  wire logic           wr_en,
  input  wire logic           rd_en,
  output logic      [15:0]    rdata,
  input  wire logic           bias_ok,
  input  wire logic           vin_ok,
  input  wire logic           stage_bias_sense,
  input  wire logic           regulator_enable_pin,
  input  wire logic [3:0]     config_resistor,
  input  wire logic           config_in_range,
  input  wire logic           main_sense_open,
  input  wire logic           aux_rail_sense_open,
  input  wire logic           main_sense_low,
  input  wire logic           aux_rail_sense_low,
  input  wire logic           phase_detect_done,
  input  wire logic           phase_detect_fault,
  input  wire logic [7:0]     load_current,
  output logic                processor_voltage_link,
  output logic                main_regulating,
  output logic                aux_regulating,
  output logic      [7:0]     main_vid,
  output logic      [7:0]     aux_vid,
  output logic                main_rail_power_good,
  output logic                aux_rail_power_good,
  output logic                fault_flag,
  output logic      [NPH-1:0] phase_enable,
  output logic                dcm_mode,
  output logic                dcm_offset_sel,
  output logic                dual_edge_modulation,
  output logic                freq_boost,
  output logic                add_offset,
  output logic      [2*NPH-1:0] steering
);
  localparam int CW = 16;
  localparam int PW = $clog2(NPH + 1);
  localparam logic [PW-1:0] NPH_P = PW'(NPH);

  // pins from the board share no clock with us
  localparam int NS = 14;
  logic [NS-1:0] pin_meta;
  logic [NS-1:0] pin_sync;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {bias_ok, vin_ok, stage_bias_sense, config_resistor, config_in_range,
                   main_sense_open, aux_rail_sense_open, main_sense_low,
                   aux_rail_sense_low, phase_detect_done, phase_detect_fault};
      pin_sync <= pin_meta;
    end
  end
  wire       s_bias   = pin_sync[13];
  wire       s_vin    = pin_sync[12];
  wire       s_stage  = pin_sync[11];
  wire [3:0] s_cfg    = pin_sync[10:7];
  wire       s_cfg_ok = pin_sync[6];
  wire       s_mopen  = pin_sync[5];
  wire       s_aopen  = pin_sync[4];
  wire       s_mlow   = pin_sync[3];
  wire       s_alow   = pin_sync[2];
  wire       s_ddone  = pin_sync[1];
  wire       s_dfault = pin_sync[0];

  logic en_level;
  rsp_deglitch #(.LOW_CYC(`RSP_DEGLITCH_CYC)) u_en (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin     (regulator_enable_pin),
    .level   (en_level)
  );

  rsp_tmr_if #(.W(CW)) ti_init ();
  rsp_tmr_if #(.W(CW)) ti_off ();
  rsp_tmr_if #(.W(CW)) ti_shed ();
  rsp_timer #(.W(CW)) u_t_init (.clk_sys(clk_sys), .rst_n(rst_n), .t(ti_init));
  rsp_timer #(.W(CW)) u_t_off (.clk_sys(clk_sys), .rst_n(rst_n), .t(ti_off));
  rsp_timer #(.W(CW)) u_t_shed (.clk_sys(clk_sys), .rst_n(rst_n), .t(ti_shed));

  // registers
  logic [15:0] mode_reg;
  logic [15:0] thresh_reg;
  logic [3:0]  status_reg;
  logic [1:0]  pstate;
  logic [7:0]  main_target;
  logic [7:0]  aux_target;
  rsp_pkg::rsp_state_t state;
  rsp_pkg::rsp_state_t next_state;

  wire shed_full   = mode_reg[`RSP_MODE_SHED_FULL];
  wire shed_single = mode_reg[`RSP_MODE_SHED_SINGLE];
  wire auto_dcm    = mode_reg[`RSP_MODE_AUTO_DCM];
  wire [7:0] phase_add_threshold  = thresh_reg[7:0];
  wire [7:0] phase_shed_threshold = thresh_reg[15:8];

  wire wr_mode   = wr_en && addr == `RSP_REG_MODE;
  wire wr_steer  = wr_en && addr == `RSP_REG_STEER;
  wire wr_thresh = wr_en && addr == `RSP_REG_THRESH;
  wire wr_set_voltage_cmd = wr_en && addr == `RSP_REG_SET_VOLTAGE_CMD;
  wire wr_pstate = wr_en && addr == `RSP_REG_PSTATE;
  wire set_voltage_cmd_aux = wdata[`RSP_SET_VOLTAGE_CMD_AUX];
  wire set_voltage_cmd_ok  = wr_set_voltage_cmd && wdata[7:0] != 8'h00;

  // boot codes from the configuration resistor; 0 means no boot voltage
  function automatic logic [7:0] boot_code(input logic [1:0] sel);
    case (sel)
      2'h1:    boot_code = `RSP_BOOT1;
      2'h2:    boot_code = `RSP_BOOT2;
      2'h3:    boot_code = `RSP_BOOT3;
      default: boot_code = 8'h00;
    endcase
  endfunction

  // startup checks
  wire [3:0] init_faults = {1'b0, s_aopen, s_mopen, !s_cfg_ok};
  wire supplies_ok = s_vin && s_stage;
  wire start_ok = supplies_ok && en_level && !ti_off.busy;
  wire enable_drop = !en_level && (state == rsp_pkg::ST_DETECT || state == rsp_pkg::ST_RUN);

  always_comb begin
    next_state = state;
    case (state)
      rsp_pkg::ST_BIAS_WAIT: if (s_bias) next_state = rsp_pkg::ST_INIT;
      rsp_pkg::ST_INIT: begin
        if (ti_init.expired) begin
          next_state = (init_faults != 4'h0) ? rsp_pkg::ST_FAULT : rsp_pkg::ST_READY;
        end
      end
      rsp_pkg::ST_FAULT: next_state = rsp_pkg::ST_FAULT;
      rsp_pkg::ST_READY: if (start_ok) next_state = rsp_pkg::ST_DETECT;
      rsp_pkg::ST_DETECT: begin
        if (s_dfault) next_state = rsp_pkg::ST_FAULT;
        else if (!en_level || !supplies_ok) next_state = rsp_pkg::ST_READY;
        else if (s_ddone) next_state = rsp_pkg::ST_RUN;
      end
      rsp_pkg::ST_RUN: if (!en_level || !supplies_ok) next_state = rsp_pkg::ST_READY;
      default: next_state = rsp_pkg::ST_BIAS_WAIT;
    endcase
    if (!s_bias) next_state = rsp_pkg::ST_BIAS_WAIT;
  end

  wire enter_init = state == rsp_pkg::ST_BIAS_WAIT && next_state == rsp_pkg::ST_INIT;
  wire entering_run = state == rsp_pkg::ST_DETECT && next_state == rsp_pkg::ST_RUN;
  wire in_run = state == rsp_pkg::ST_RUN;

  assign ti_init.start = enter_init;
  assign ti_init.stop  = !s_bias;
  assign ti_init.load  = CW'(INIT_CYC);
  assign ti_off.start  = enable_drop;
  assign ti_off.stop   = 1'b0;
  assign ti_off.load   = CW'(`RSP_OFF_MIN_CYC);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) state <= rsp_pkg::ST_BIAS_WAIT;
    else state <= next_state;
  end

  // software registers; fault log is sticky until the supply reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg   <= `RSP_MODE_RESET;
      steering   <= `RSP_STEER_RESET;
      thresh_reg <= `RSP_THRESH_RESET;
      pstate     <= 2'h0;
      status_reg <= 4'h0;
      fault_flag <= 1'b0;
    end else begin
      if (wr_mode) mode_reg <= wdata;
      if (wr_steer) steering <= wdata;
      if (wr_thresh) thresh_reg <= wdata;
      if (wr_pstate) pstate <= wdata[1:0];
      if (state == rsp_pkg::ST_INIT && ti_init.expired) begin
        status_reg <= status_reg | init_faults;
      end
      if (state == rsp_pkg::ST_DETECT && s_dfault) begin
        status_reg[`RSP_ST_DETECT] <= 1'b1;
      end
      if (next_state == rsp_pkg::ST_FAULT) fault_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dcm_offset_sel       <= 1'b0;
      dual_edge_modulation <= 1'b0;
    end else begin
      dcm_offset_sel       <= mode_reg[`RSP_MODE_DCM_OFFSET];
      dual_edge_modulation <= mode_reg[`RSP_MODE_DUAL_EDGE];
    end
  end

  // targets: boot code at init, replaced by set-voltage commands
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      main_target <= 8'h00;
      aux_target  <= 8'h00;
    end else if (state == rsp_pkg::ST_INIT) begin
      main_target <= boot_code(s_cfg[1:0]);
      aux_target  <= boot_code(s_cfg[3:2]);
    end else if (set_voltage_cmd_ok && processor_voltage_link) begin
      if (set_voltage_cmd_aux) aux_target <= wdata[7:0];
      else main_target <= wdata[7:0];
    end
  end

  // slow ramp-rate tick
  logic [15:0] ramp_cnt;
  wire ramp_tick = ramp_cnt == 16'(RAMP_STEP - 1);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) ramp_cnt <= 16'h0000;
    else if (ramp_tick || !in_run) ramp_cnt <= 16'h0000;
    else ramp_cnt <= ramp_cnt + 16'h0001;
  end

  // each rail starts on its own once its sense is low and it has a target
  wire main_go = in_run && s_mlow && main_target != 8'h00;
  wire aux_go  = in_run && s_alow && aux_target != 8'h00;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      processor_voltage_link <= 1'b0;
      main_regulating        <= 1'b0;
      aux_regulating         <= 1'b0;
      main_vid               <= 8'h00;
      aux_vid                <= 8'h00;
      main_rail_power_good   <= 1'b0;
      aux_rail_power_good    <= 1'b0;
    end else if (!in_run) begin
      processor_voltage_link <= entering_run;
      main_regulating        <= 1'b0;
      aux_regulating         <= 1'b0;
      main_vid               <= 8'h00;
      aux_vid                <= 8'h00;
      main_rail_power_good   <= 1'b0;
      aux_rail_power_good    <= 1'b0;
    end else begin
      processor_voltage_link <= 1'b1;
      if (main_go) main_regulating <= 1'b1;
      if (aux_go) aux_regulating <= 1'b1;
      if (main_regulating && ramp_tick && main_vid != main_target) begin
        main_vid <= (main_vid < main_target) ? main_vid + 8'h01 : main_vid - 8'h01;
      end
      if (aux_regulating && ramp_tick && aux_vid != aux_target) begin
        aux_vid <= (aux_vid < aux_target) ? aux_vid + 8'h01 : aux_vid - 8'h01;
      end
      // stays up through later voltage moves
      if (main_regulating && main_vid == main_target) main_rail_power_good <= 1'b1;
      if (aux_regulating && aux_vid == aux_target) aux_rail_power_good <= 1'b1;
    end
  end

  // phase management
  logic [PW-1:0] ph_cnt;
  logic          shed_first;
  logic [15:0]   boost_cnt;
  wire ps_two  = pstate == 2'(rsp_pkg::PS_TWO) || pstate == 2'(rsp_pkg::PS_THREE);
  wire single_ok = shed_single || ps_two;
  wire [PW-1:0] floor_cnt = single_ok ? PW'(1) : PW'(2);
  wire shed_on = in_run && (shed_full || ps_two);
  wire load_hi = load_current > phase_add_threshold;
  wire load_lo = load_current < phase_shed_threshold;
  wire can_shed = shed_on && load_lo && ph_cnt > floor_cnt;
  wire fast_drop = can_shed && dual_edge_modulation;
  wire do_add = in_run && (load_hi || ph_cnt < floor_cnt) && ph_cnt != NPH_P;

  assign ti_shed.start = can_shed && !fast_drop && (!ti_shed.busy || ti_shed.expired);
  assign ti_shed.stop  = !can_shed;
  assign ti_shed.load  = (shed_first && !ti_shed.expired) ? CW'(`RSP_SHED_FIRST_CYC) :
                         CW'(`RSP_SHED_NEXT_CYC);

  wire shed_step = !do_add && can_shed && (fast_drop || ti_shed.expired);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ph_cnt     <= NPH_P;
      shed_first <= 1'b1;
    end else if (!in_run || !shed_on || do_add) begin
      ph_cnt     <= NPH_P;
      shed_first <= 1'b1;
    end else if (shed_step) begin
      ph_cnt     <= fast_drop ? floor_cnt : ph_cnt - PW'(1);
      shed_first <= 1'b0;
    end else if (!load_lo) begin
      shed_first <= 1'b1;
    end
  end

  // a transition raises frequency for one later-shed interval
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      boost_cnt  <= 16'h0000;
      freq_boost <= 1'b0;
      add_offset <= 1'b0;
    end else begin
      if (do_add || shed_step) boost_cnt <= 16'(`RSP_BOOST_CYC);
      else if (boost_cnt != 16'h0000) boost_cnt <= boost_cnt - 16'h0001;
      freq_boost <= do_add || shed_step || boost_cnt > 16'h0001;
      if (do_add) add_offset <= 1'b1;
      else if (boost_cnt <= 16'h0001) add_offset <= 1'b0;
    end
  end

  // phase mask and conduction mode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_enable <= '0;
      dcm_mode     <= 1'b0;
    end else begin
      for (int i = 0; i < NPH; i++) begin
        phase_enable[i] <= in_run && (PW'(i) < ph_cnt);
      end
      dcm_mode <= in_run && ph_cnt == PW'(1) && (auto_dcm || ps_two);
    end
  end

  // read port, data in the cycle after the strobe
  logic [15:0] rd_mux;
  assign rd_mux = (addr == `RSP_REG_MODE)   ? mode_reg :
                  (addr == `RSP_REG_STEER)  ? steering :
                  (addr == `RSP_REG_THRESH) ? thresh_reg :
                  (addr == `RSP_REG_STATUS) ? {12'h000, status_reg} :
                  (addr == `RSP_REG_PSTATE) ? {14'h0000, pstate} :
                  (addr == `RSP_REG_SET_VOLTAGE_CMD) ? {aux_target, main_target} :
                  (addr == `RSP_REG_STATE)  ? {4'h0, 4'(ph_cnt), 3'h0,
                                               aux_rail_power_good, main_rail_power_good,
                                               state} :
                  16'h0000;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rdata <= 16'h0000;
    else if (rd_en) rdata <= rd_mux;
    else rdata <= 16'h0000;
  end
endmodule

//--- hdl/rsp_defines.svh
`ifndef RSP_DEFINES_SVH
`define RSP_DEFINES_SVH

`define RSP_CLK_HZ        20000000
`define RSP_CLK_MHZ       (`RSP_CLK_HZ / 1000000)

// times as printed, then cycle counts at the system clock
`define RSP_INIT_US       800
`define RSP_OFF_MIN_US    200
`define RSP_SHED_FIRST_US 200
`define RSP_SHED_NEXT_US  20
`define RSP_DEGLITCH_NS   200
`define RSP_INIT_CYC      (`RSP_INIT_US * `RSP_CLK_MHZ)
`define RSP_OFF_MIN_CYC   (`RSP_OFF_MIN_US * `RSP_CLK_MHZ)
`define RSP_SHED_FIRST_CYC (`RSP_SHED_FIRST_US * `RSP_CLK_MHZ)
`define RSP_SHED_NEXT_CYC (`RSP_SHED_NEXT_US * `RSP_CLK_MHZ)
`define RSP_DEGLITCH_CYC  ((`RSP_DEGLITCH_NS * `RSP_CLK_MHZ + 999) / 1000)
`define RSP_RAMP_STEP_CYC 20
`define RSP_BOOST_CYC     (`RSP_SHED_NEXT_US * `RSP_CLK_MHZ)

// register offsets
`define RSP_REG_MODE      8'hB3
`define RSP_REG_STEER     8'hB4
`define RSP_REG_STATUS    8'hF9
`define RSP_REG_THRESH    8'hC0
`define RSP_REG_SET_VOLTAGE_CMD    8'hC2
`define RSP_REG_PSTATE    8'hC3
`define RSP_REG_STATE     8'hC4

// mode register fields
`define RSP_MODE_SHED_FULL   0
`define RSP_MODE_SHED_SINGLE 1
`define RSP_MODE_AUTO_DCM    2
`define RSP_MODE_DUAL_EDGE   3
`define RSP_MODE_DCM_OFFSET  6
`define RSP_MODE_RESET    16'h0007
`define RSP_STEER_RESET   16'h0000
`define RSP_THRESH_RESET  16'h2060
`define RSP_SET_VOLTAGE_CMD_AUX    8

// status bits
`define RSP_ST_CFG_BAD    0
`define RSP_ST_MAIN_OPEN  1
`define RSP_ST_AUX_OPEN   2
`define RSP_ST_DETECT     3

// boot codes selected by the configuration resistor
`define RSP_BOOT1         8'h50
`define RSP_BOOT2         8'h64
`define RSP_BOOT3         8'h78

`endif

//--- hdl/rsp_pkg.sv
package rsp_pkg;
  typedef enum logic [2:0] {
    ST_BIAS_WAIT,
    ST_INIT,
    ST_FAULT,
    ST_READY,
    ST_DETECT,
    ST_RUN
  } rsp_state_t;

  typedef enum logic [1:0] {
    PS_FULL,
    PS_ONE,
    PS_TWO,
    PS_THREE
  } rsp_pstate_t;
endpackage

//--- hdl/rsp_tmr_if.sv
`timescale 1ns/1ps
interface rsp_tmr_if #(parameter int W = 16);
  logic         start;
  logic         stop;
  logic [W-1:0] load;
  logic         busy;
  logic         expired;
  modport ctl (output start, stop, load, input busy, expired);
  modport tmr (input start, stop, load, output busy, expired);
endinterface

//--- hdl/rsp_timer.sv
`timescale 1ns/1ps
// one-shot down counter; start while busy restarts it
module rsp_timer #(
  parameter int W = 16
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  rsp_tmr_if.tmr    t
);
  logic [W-1:0] cnt;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt       <= '0;
      t.busy    <= 1'b0;
      t.expired <= 1'b0;
    end else begin
      t.expired <= 1'b0;
      if (t.start) begin
        cnt    <= t.load;
        t.busy <= 1'b1;
      end else if (t.stop) begin
        t.busy <= 1'b0;
      end else if (t.busy) begin
        if (cnt <= W'(1)) begin
          t.busy    <= 1'b0;
          t.expired <= 1'b1;
        end
        cnt <= cnt - W'(1);
      end
    end
  end
endmodule

//--- hdl/rsp_deglitch.sv
`timescale 1ns/1ps
// pin synchroniser plus low-pulse filter: a low is passed only after it
// has held for LOW_CYC cycles, a high passes at once
module rsp_deglitch #(
  parameter int LOW_CYC = 4
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level
);
  logic       meta;
  logic       sync;
  logic [7:0] low_cnt;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta    <= 1'b0;
      sync    <= 1'b0;
      low_cnt <= 8'h00;
      level   <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      if (sync) begin
        low_cnt <= 8'h00;
        level   <= 1'b1;
      end else if (low_cnt >= 8'(LOW_CYC - 1)) begin
        level <= 1'b0;
      end else begin
        low_cnt <= low_cnt + 8'h01;
      end
    end
  end
endmodule

//--- tb/rsp_host_model.sv
`timescale 1ns/1ps
// host side of the register port; voltage and power-state commands are
// plain register writes, so the whole link reduces to these two tasks
module rsp_host_model (
  input  wire logic        clk_sys,
  output logic      [7:0]  addr,
  output logic      [15:0] wdata,
  output logic             wr_en,
  output logic             rd_en,
  input  wire logic [15:0] rdata
);
  initial begin
    addr = 8'h00;
    wdata = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(posedge clk_sys);
    v = rdata;
  endtask
endmodule

//--- tb/rsp_sequencer_sva.sv
`timescale 1ns/1ps
module rsp_sequencer_sva #(
  parameter int NPH = 8
) (
  input wire logic             clk_sys,
  input wire logic             rst_n,
  input wire logic [7:0]       addr,
  input wire logic [15:0]      wdata,
  input wire logic             wr_en,
  input wire logic             rd_en,
  input wire logic [15:0]      rdata,
  input wire logic [7:0]       load_current,
  input wire logic             aux_rail_sense_low,
  input wire logic             processor_voltage_link,
  input wire logic             main_regulating,
  input wire logic             aux_regulating,
  input wire logic             main_rail_power_good,
  input wire logic             aux_rail_power_good,
  input wire logic             fault_flag,
  input wire logic [NPH-1:0]   phase_enable,
  input wire logic             dcm_mode,
  input wire logic             dual_edge_modulation,
  input wire logic             freq_boost,
  input wire logic [2*NPH-1:0] steering
);
  // reset add threshold; valid only while nobody rewrites it
  localparam logic [7:0] ADD_THR = 8'h60;
  localparam int         OFF_MIN = 3990;
  logic [12:0] since_off;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      since_off <= 13'h1FFF;
    end else if ($fell(processor_voltage_link)) begin
      since_off <= 13'h0000;
    end else if (since_off != 13'h1FFF) begin
      since_off <= since_off + 13'h0001;
    end
  end
  sequence s_change;
    processor_voltage_link && $past(processor_voltage_link) && $past(phase_enable) != '0
      && $countones(phase_enable) != $countones($past(phase_enable));
  endsequence
  sequence s_shrink;
    processor_voltage_link && $past(processor_voltage_link) && !dual_edge_modulation
      && $countones(phase_enable) < $countones($past(phase_enable));
  endsequence
  property p_add_all;
    processor_voltage_link && load_current > ADD_THR
      |-> ##2 (!processor_voltage_link || &phase_enable);
  endproperty
  property p_shed_step;
    s_shrink |-> $countones(phase_enable) == $countones($past(phase_enable)) - 1;
  endproperty
  property p_boost;
    s_change |-> ##[0:1] freq_boost;
  endproperty
  property p_dcm_single;
    $rose(dcm_mode) |-> $countones(phase_enable) == 1;
  endproperty
  property p_restart_gap;
    $rose(processor_voltage_link) |-> since_off >= OFF_MIN;
  endproperty
  property p_aux_sense;
    $rose(aux_regulating) |-> $past(aux_rail_sense_low);
  endproperty
  property p_pg_main;
    main_rail_power_good |-> main_regulating;
  endproperty
  property p_pg_aux;
    aux_rail_power_good |-> aux_regulating;
  endproperty
  property p_fault_hold;
    fault_flag |=> fault_flag && !processor_voltage_link && !main_regulating;
  endproperty
  property p_steer;
    wr_en && addr == 8'hB4 |-> ##2 steering == $past(wdata, 2);
  endproperty
  property p_rdata_idle;
    !rd_en |=> rdata == 16'h0000;
  endproperty
  a_add_all: assert property (p_add_all) else $error("phase add missed");
  a_shed_step: assert property (p_shed_step) else $error("shed not one step");
  a_boost: assert property (p_boost) else $error("no boost on count change");
  a_dcm_single: assert property (p_dcm_single) else $error("dcm with many phases");
  a_restart_gap: assert property (p_restart_gap) else $error("restart too soon");
  a_aux_sense: assert property (p_aux_sense) else $error("aux start, sense high");
  a_pg_main: assert property (p_pg_main) else $error("main good, not regulating");
  a_pg_aux: assert property (p_pg_aux) else $error("aux good, not regulating");
  a_fault_hold: assert property (p_fault_hold) else $error("fault not held off");
  a_steer: assert property (p_steer) else $error("steering not loaded");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
endmodule
bind rsp_sequencer rsp_sequencer_sva #(.NPH(NPH)) i_sva (
  .clk_sys, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .load_current, .aux_rail_sense_low,
  .processor_voltage_link, .main_regulating, .aux_regulating, .main_rail_power_good,
  .aux_rail_power_good, .fault_flag, .phase_enable, .dcm_mode, .dual_edge_modulation,
  .freq_boost, .steering);

//--- tb/rsp_sequencer_tb.sv
`timescale 1ns/1ps
module rsp_sequencer_tb;
  localparam int LIMIT = 60000;
  logic        clk_sys, rst_n, bias_ok, vin_ok, regulator_enable_pin, config_in_range;
  logic        main_sense_open, aux_rail_sense_low, phase_detect_done, wr_en, rd_en;
  logic        processor_voltage_link, main_regulating, aux_regulating, fault_flag;
  logic        main_rail_power_good, aux_rail_power_good, dcm_mode, dcm_offset_sel;
  logic        dual_edge_modulation, freq_boost, add_offset;
  logic        stage_bias_sense, phase_detect_fault;
  logic [3:0]  config_resistor;
  logic [7:0]  load_current, addr, main_vid, aux_vid, phase_enable;
  logic [15:0] wdata, rdata, steering, d;
  int          error_cnt, checks_done, cyc, n;
  rsp_sequencer #(.NPH(8), .INIT_CYC(50), .RAMP_STEP(2)) i_dut (
    .clk_sys, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .bias_ok, .vin_ok,
    .stage_bias_sense, .regulator_enable_pin, .config_resistor, .config_in_range,
    .main_sense_open, .aux_rail_sense_open(1'b0), .main_sense_low(1'b1), .aux_rail_sense_low,
    .phase_detect_done, .phase_detect_fault, .load_current, .processor_voltage_link,
    .main_regulating, .aux_regulating, .main_vid, .aux_vid, .main_rail_power_good,
    .aux_rail_power_good, .fault_flag, .phase_enable, .dcm_mode, .dcm_offset_sel,
    .dual_edge_modulation, .freq_boost, .add_offset, .steering);
  rsp_host_model i_host (.clk_sys, .addr, .wdata, .wr_en, .rd_en, .rdata);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic end_of_test();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] exp);
    i_host.rd(a, d);
    chk(d & m, exp);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic wait_ph(input int ph);
    for (n = 0; n < 8000 && $countones(phase_enable) != ph; n++) tick(1);
  endtask
  task automatic t_regs();
    rchk(8'hB3, 16'hFFFF, 16'h0007);
    rchk(8'hC0, 16'hFFFF, 16'h2060);
    rchk(8'h10, 16'hFFFF, 16'h0000);
    i_host.wr(8'hF9, 16'hFFFF);
    rchk(8'hF9, 16'hFFFF, 16'h0000);
    i_host.wr(8'hB3, 16'h0047);
    tick(3);
    chkb(dcm_offset_sel, 1'b1);
    i_host.wr(8'hB4, 16'hE41B);
    tick(3);
    chk(steering, 16'hE41B);
  endtask
  task automatic t_start();
    // enable is already high and the input supply still low: order must not matter
    bias_ok <= 1'b1;
    tick(20);
    rchk(8'hC4, 16'h0007, 16'h0001);
    tick(60);
    rchk(8'hC4, 16'h0007, 16'h0003);
    chkb(processor_voltage_link, 1'b0);
    vin_ok <= 1'b1;
    tick(10);
    rchk(8'hC4, 16'h0007, 16'h0004);
    chkb(processor_voltage_link, 1'b0);
    phase_detect_done <= 1'b1;
    for (n = 0; n < 20 && processor_voltage_link !== 1'b1; n++) tick(1);
    chkb(processor_voltage_link, 1'b1);
    chkb(aux_regulating, 1'b0);
    for (n = 0; n < 400 && main_rail_power_good !== 1'b1; n++) tick(1);
    chk({8'h00, main_vid}, 16'h0050);
    chkb(aux_rail_power_good, 1'b0);
    i_host.wr(8'hC2, 16'h0140);
    tick(200);
    chkb(aux_regulating, 1'b0);
    aux_rail_sense_low <= 1'b1;
    for (n = 0; n < 400 && aux_rail_power_good !== 1'b1; n++) tick(1);
    chk({8'h00, aux_vid}, 16'h0040);
  endtask
  task automatic t_shed();
    load_current <= 8'h70;
    tick(3);
    chk({8'h00, phase_enable}, 16'h00FF);
    load_current <= 8'h10;
    wait_ph(7);
    chk(16'((n + 5) / 10), 16'h0190);
    tick(2);
    chkb(freq_boost, 1'b1);
    wait_ph(6);
    chk(16'((n + 7) / 10), 16'h0028);
    wait_ph(1);
    chk(16'((n + 50) / 100), 16'h0014);
    tick(3);
    chkb(dcm_mode, 1'b1);
    load_current <= 8'h70;
    tick(3);
    chk({8'h00, phase_enable}, 16'h00FF);
    chkb(add_offset, 1'b1);
    i_host.wr(8'hB3, 16'h0001);
    load_current <= 8'h10;
    wait_ph(2);
    tick(1000);
    chk(16'($countones(phase_enable)), 16'h0002);
    chkb(dcm_mode, 1'b0);
    i_host.wr(8'hC3, 16'h0002);
    wait_ph(1);
    tick(3);
    chkb(dcm_mode, 1'b1);
    i_host.wr(8'hC3, 16'h0000);
    i_host.wr(8'hB3, 16'h000F);
    load_current <= 8'h70;
    tick(3);
    chkb(dual_edge_modulation, 1'b1);
    load_current <= 8'h10;
    for (n = 0; n < 8000 && phase_enable === 8'hFF; n++) tick(1);
    tick(1);
    chk(16'($countones(phase_enable)), 16'h0001);
  endtask
  task automatic t_off();
    regulator_enable_pin <= 1'b0;
    tick(2);
    regulator_enable_pin <= 1'b1;
    tick(12);
    chkb(processor_voltage_link, 1'b1);
    regulator_enable_pin <= 1'b0;
    tick(8);
    regulator_enable_pin <= 1'b1;
    for (n = 0; n < 20 && processor_voltage_link !== 1'b0; n++) tick(1);
    chkb(processor_voltage_link, 1'b0);
    tick(3800);
    chkb(processor_voltage_link, 1'b0);
    for (n = 0; n < 400 && processor_voltage_link !== 1'b1; n++) tick(1);
    chkb(processor_voltage_link, 1'b1);
    regulator_enable_pin <= 1'b0;
    tick(20);
    bias_ok <= 1'b0;
  endtask
  task automatic t_fault();
    rst_n <= 1'b0;
    config_in_range <= 1'b0;
    main_sense_open <= 1'b1;
    regulator_enable_pin <= 1'b1;
    tick(4);
    rst_n <= 1'b1;
    bias_ok <= 1'b1;
    tick(100);
    chkb(fault_flag, 1'b1);
    chkb(processor_voltage_link, 1'b0);
    rchk(8'hF9, 16'h000F, 16'h0003);
    rchk(8'hC4, 16'h0007, 16'h0002);
  endtask
  initial begin
    rst_n = 1'b0;
    bias_ok = 1'b0;
    vin_ok = 1'b0;
    regulator_enable_pin = 1'b1;
    stage_bias_sense = 1'b1;
    phase_detect_fault = 1'b0;
    config_in_range = 1'b1;
    main_sense_open = 1'b0;
    aux_rail_sense_low = 1'b0;
    phase_detect_done = 1'b0;
    config_resistor = 4'h1;
    load_current = 8'h00;
    tick(4);
    rst_n <= 1'b1;
    t_regs();
    t_start();
    t_shed();
    t_off();
    t_fault();
    end_of_test();
  end
endmodule
